// [rtl/brl_pkg.sv]
// Purpose: Constants and carriers for the boost limit and ADC readback registers
// Assumes: 16-bit register words addressed by an 8-bit command code
// Notes: Millivolt figures are integers; the voltage step is 16656/2048 mV
package brl_pkg;
  // Command codes (register offsets)
  localparam logic [7:0] BRL_ADC_READBACK_OFF = 8'h23;
  localparam logic [7:0] BRL_BOOST_VOLT_OFF = 8'h3b;
  localparam logic [7:0] BRL_BOOST_CURR_OFF = 8'h3c;
  // Voltage limit field layout
  localparam int BRL_VOLT_LSB = 2;
  localparam int BRL_VOLT_MSB = 13;
  localparam int BRL_VOLT_RSV_LSB = 14;
  // Current limit field layout
  localparam int BRL_CURR_LSB = 8;
  localparam int BRL_CURR_MSB = 14;
  localparam int BRL_CURR_RSV_BIT = 15;
  // Reset values
  localparam logic [11:0] BRL_VOLT_RESET = 12'h000;
  localparam logic [6:0] BRL_CURR_RESET = 7'h00;
  localparam logic [15:0] BRL_ADC_RESET = 16'h0000;
  // Voltage scale: top bit weight over top bit value (2048)
  localparam logic [31:0] BRL_VOLT_TOP_MV = 32'd16656;
  localparam int BRL_VOLT_SCALE_SHIFT = 11;
  localparam logic [15:0] BRL_VOLT_MIN_MV = 16'd3000;
  localparam logic [15:0] BRL_VOLT_MAX_MV = 16'd20800;
  localparam logic [15:0] BRL_VOLT_OFFSET_MV = 16'd1280;
  // Current scale
  localparam logic [5:0] BRL_CURR_STEP_MA = 6'd50;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } brl_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] input_bus_voltage;
    logic [7:0] system_power_monitor;
  } brl_adc_t;

  typedef struct packed {
    logic [11:0] volt_r;
    logic [6:0] curr_r;
    logic [15:0] adc_r;
    logic [15:0] rdata_r;
    logic rvalid_r;
    logic rejected_r;
    logic clamped_r;
    logic [15:0] volt_mv_r;
    logic [12:0] curr_ma_r;
  } brl_state_t;
endpackage

// [rtl/brl_regs.sv]
// Purpose: Boost output limit registers and input bus / system power ADC readback
// Assumes: SMBus framing is decoded outside; one request per cycle at most
// Notes: Answers and flags appear one cycle after the request is taken

// How it works
// - Bits 13:2 of the boost voltage register hold a 12-bit limit whose value sets the voltage.
// - A write with ones in the upper reserved bits of either limit register is rejected as invalid.
// - The low reserved bits of both limit registers are dropped on write and read back as zero.
// - Bits 14:8 of the boost current register hold a 7-bit limit in 50 mA steps.
// - Both limit registers come out of reset as zero.
// - The readback register shows the input bus voltage code in its upper byte.
// - The readback register shows the system power monitor code in its lower byte.
// - A voltage write whose resulting setting is below 3 V or above 20.8 V is ignored.
// - With the offset disable input low, 1.28 V is added to the voltage setting.
module brl_regs (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // Register requests
  input brl_pkg::brl_req_t i_req,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  output logic o_write_rejected,
  output logic o_write_clamped,
  // Converter side
  input brl_pkg::brl_adc_t i_adc,
  input wire logic i_volt_offset_disable,
  output logic [15:0] o_boost_voltage_mv,
  output logic [12:0] o_boost_current_ma
);
  import brl_pkg::*;

  brl_state_t st_r;
  brl_state_t st_nxt;

  // Setting in mV; offset tracks the live input, not the value at write time
  function automatic logic [15:0] volt_mv(input logic [11:0] code, input logic off_dis);
    logic [31:0] prod;
    prod = ({20'h0, code} * BRL_VOLT_TOP_MV) >> BRL_VOLT_SCALE_SHIFT;
    return prod[15:0] + (off_dis ? 16'h0000 : BRL_VOLT_OFFSET_MV);
  endfunction

  logic [11:0] wr_volt_code;
  logic [15:0] wr_volt_mv;
  logic wr_volt;
  logic wr_curr;
  assign wr_volt_code = i_req.wdata[BRL_VOLT_MSB:BRL_VOLT_LSB];
  assign wr_volt_mv = volt_mv(wr_volt_code, i_volt_offset_disable);
  assign wr_volt = i_req.wr && i_req.cmd == BRL_BOOST_VOLT_OFF;
  assign wr_curr = i_req.wr && i_req.cmd == BRL_BOOST_CURR_OFF;

  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid_r = i_req.rd;
    st_nxt.rejected_r = 1'b0;
    st_nxt.clamped_r = 1'b0;
    if (i_adc.valid) begin
      st_nxt.adc_r = {i_adc.input_bus_voltage, i_adc.system_power_monitor};
    end
    if (wr_volt) begin
      if (i_req.wdata[15:BRL_VOLT_RSV_LSB] != 2'b00) begin
        st_nxt.rejected_r = 1'b1;
      end else if (wr_volt_mv < BRL_VOLT_MIN_MV || wr_volt_mv > BRL_VOLT_MAX_MV) begin
        st_nxt.clamped_r = 1'b1;
      end else begin
        st_nxt.volt_r = wr_volt_code;
      end
    end
    if (wr_curr) begin
      if (i_req.wdata[BRL_CURR_RSV_BIT]) begin
        st_nxt.rejected_r = 1'b1;
      end else begin
        st_nxt.curr_r = i_req.wdata[BRL_CURR_MSB:BRL_CURR_LSB];
      end
    end
    // Writes to the readback code fall through here untouched
    if (i_req.rd) begin
      unique case (i_req.cmd)
        BRL_ADC_READBACK_OFF: st_nxt.rdata_r = st_r.adc_r;
        BRL_BOOST_VOLT_OFF: st_nxt.rdata_r = {2'b00, st_r.volt_r, 2'b00};
        BRL_BOOST_CURR_OFF: st_nxt.rdata_r = {1'b0, st_r.curr_r, 8'h00};
        default: st_nxt.rdata_r = 16'h0000;
      endcase
    end
    st_nxt.volt_mv_r = volt_mv(st_r.volt_r, i_volt_offset_disable);
    st_nxt.curr_ma_r = 13'(st_r.curr_r * BRL_CURR_STEP_MA);
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= '{volt_r: BRL_VOLT_RESET, curr_r: BRL_CURR_RESET, adc_r: BRL_ADC_RESET,
                rdata_r: 16'h0000, rvalid_r: 1'b0, rejected_r: 1'b0, clamped_r: 1'b0,
                volt_mv_r: 16'h0000, curr_ma_r: 13'h0000};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata = st_r.rdata_r;
  assign o_rvalid = st_r.rvalid_r;
  assign o_write_rejected = st_r.rejected_r;
  assign o_write_clamped = st_r.clamped_r;
  assign o_boost_voltage_mv = st_r.volt_mv_r;
  assign o_boost_current_ma = st_r.curr_ma_r;

  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  // Request shapes, one per outcome the slice must produce
  sequence s_good_volt_write;
    wr_volt && i_req.wdata[15:14] == 2'b00 &&
      wr_volt_mv >= BRL_VOLT_MIN_MV && wr_volt_mv <= BRL_VOLT_MAX_MV;
  endsequence

  sequence s_volt_rsv_write;
    wr_volt && i_req.wdata[15:14] != 2'b00;
  endsequence

  sequence s_volt_out_range;
    wr_volt && i_req.wdata[15:14] == 2'b00 &&
      (wr_volt_mv < 16'd3000 || wr_volt_mv > 16'd20800);
  endsequence

  sequence s_good_curr_write;
    wr_curr && !i_req.wdata[15];
  endsequence

  sequence s_curr_rsv_write;
    wr_curr && i_req.wdata[15];
  endsequence

  sequence s_volt_read;
    i_req.rd && i_req.cmd == BRL_BOOST_VOLT_OFF;
  endsequence

  sequence s_curr_read;
    i_req.rd && i_req.cmd == BRL_BOOST_CURR_OFF;
  endsequence

  sequence s_adc_capture_read;
    i_adc.valid ##1 (i_req.rd && i_req.cmd == BRL_ADC_READBACK_OFF);
  endsequence

  sequence s_unmapped_read;
    i_req.rd && i_req.cmd != BRL_ADC_READBACK_OFF && i_req.cmd != BRL_BOOST_VOLT_OFF &&
      i_req.cmd != BRL_BOOST_CURR_OFF;
  endsequence

  // Voltage limit
  a_volt_write_lands: assert property (s_good_volt_write |=> st_r.volt_r == $past(i_req.wdata[13:2]))
    else $error("voltage limit not stored");
  a_volt_read_layout: assert property (s_volt_read |=>
    o_rvalid && o_rdata == {2'b00, $past(st_r.volt_r), 2'b00})
    else $error("voltage readback layout wrong");
  a_volt_rsv_reject: assert property (s_volt_rsv_write |=> o_write_rejected && $stable(st_r.volt_r))
    else $error("voltage write with reserved ones not rejected");
  a_clamp_ignore: assert property (s_volt_out_range |=> o_write_clamped && $stable(st_r.volt_r))
    else $error("out of range voltage write not ignored");
  a_volt_no_write: assert property (!wr_volt |=> $stable(st_r.volt_r))
    else $error("voltage limit changed without a write");
  // Offset follows the live input, so sums are checked once the setting has settled
  a_offset_added: assert property ($stable(st_r.volt_r) && !i_volt_offset_disable && st_r.volt_r != 12'h000 |=>
    o_boost_voltage_mv == 16'(({20'h0, $past(st_r.volt_r)} * 32'd16656) >> 11) + 16'd1280)
    else $error("voltage offset not applied");
  a_offset_dropped: assert property ($stable(st_r.volt_r) && i_volt_offset_disable |=>
    o_boost_voltage_mv == 16'(({20'h0, $past(st_r.volt_r)} * 32'd16656) >> 11))
    else $error("voltage offset applied while disabled");

  // Current limit
  a_curr_write_lands: assert property (s_good_curr_write |=> st_r.curr_r == $past(i_req.wdata[14:8]))
    else $error("current limit not stored");
  a_curr_rsv_reject: assert property (s_curr_rsv_write |=> o_write_rejected && $stable(st_r.curr_r))
    else $error("current write with reserved one not rejected");
  a_low_bits_zero: assert property (s_curr_read |=>
    o_rvalid && o_rdata[7:0] == 8'h00 && o_rdata[15] == 1'b0)
    else $error("current readback reserved bits not zero");
  a_curr_read_layout: assert property (s_curr_read |=>
    o_rdata[14:8] == $past(st_r.curr_r))
    else $error("current readback field wrong");
  a_curr_output: assert property (s_good_curr_write |=> ##1
    o_boost_current_ma == 13'($past(i_req.wdata[14:8], 2) * 50))
    else $error("current limit output wrong");
  a_curr_out_steady: assert property ($stable(st_r.curr_r) |=>
    o_boost_current_ma == 13'($past(st_r.curr_r) * 50))
    else $error("current output does not follow limit");
  a_curr_no_write: assert property (!wr_curr |=> $stable(st_r.curr_r))
    else $error("current limit changed without a write");

  // Flags and read port
  a_flags_idle: assert property (!i_req.wr |=> !o_write_rejected && !o_write_clamped)
    else $error("write flag without a write");
  a_read_valid: assert property (i_req.rd |=> o_rvalid)
    else $error("read not answered");
  a_rvalid_idle: assert property (!i_req.rd |=> !o_rvalid)
    else $error("read valid without a read");
  a_rdata_holds: assert property (!i_req.rd |=> $stable(o_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (s_unmapped_read |=> o_rvalid && o_rdata == 16'h0000)
    else $error("unmapped read not zero");

  // Reset
  a_reset_zero: assert property (@(posedge i_clock) disable iff (1'b0)
    !i_reset_n |-> st_r.volt_r == 12'h000 && st_r.curr_r == 7'h00)
    else $error("limit registers not zero in reset");
  a_reset_outputs: assert property (@(posedge i_clock) disable iff (1'b0)
    !i_reset_n |-> o_boost_voltage_mv == 16'h0000 && o_boost_current_ma == 13'h0000 && !o_rvalid)
    else $error("outputs not quiet in reset");

  // Readback
  a_adc_capture: assert property (i_adc.valid |=>
    st_r.adc_r == {$past(i_adc.input_bus_voltage), $past(i_adc.system_power_monitor)})
    else $error("ADC codes not captured");
  a_adc_bytes: assert property (s_adc_capture_read |=>
    o_rdata == {$past(i_adc.input_bus_voltage, 2), $past(i_adc.system_power_monitor, 2)})
    else $error("readback bytes do not match ADC codes");
  a_adc_read_only: assert property (i_req.wr && i_req.cmd == BRL_ADC_READBACK_OFF && !i_adc.valid |=>
    $stable(st_r.adc_r))
    else $error("write changed readback register");
  a_adc_holds: assert property (!i_adc.valid |=> $stable(st_r.adc_r))
    else $error("readback codes moved without a capture");
endmodule // brl_regs

// [sim/brl_adc_model.sv]
// Purpose: Converter side that hands new ADC codes to the register slice
// Assumes: One valid pulse per i_go seen at a falling edge
// Notes: Codes are inverted at each falling edge outside valid, so a stale value comes back only every other cycle
module brl_adc_model (
  // Control from the bench
  input wire logic i_clock,
  input wire logic i_go,
  input wire logic [15:0] i_codes,
  // Toward the design
  output brl_pkg::brl_adc_t o_adc
);
  timeunit 1ns;
  timeprecision 1ps;
  import brl_pkg::*;
  initial o_adc = '0;
  always @(negedge i_clock) begin
    o_adc <= i_go ? {1'b1, i_codes} : {1'b0, ~o_adc[15:0]};
  end
endmodule // brl_adc_model

// [sim/testbench.sv]
// Purpose: Register-level checks of the boost limits and ADC readback
// Assumes: Inputs change at falling edges only
// Notes: Offset disable is toggled to see both voltage sums
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import brl_pkg::*;
  logic i_clock = 0, i_reset_n = 0, i_volt_offset_disable = 0, adc_go = 0;
  brl_req_t i_req = '0;
  brl_adc_t i_adc;
  logic [15:0] o_rdata, o_boost_voltage_mv;
  logic [12:0] o_boost_current_ma;
  logic o_rvalid, o_write_rejected, o_write_clamped;
  int err_count = 0, samples_checked = 0;
  always #5 i_clock = ~i_clock;
  brl_regs u_dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_req(i_req), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .o_write_rejected(o_write_rejected), .o_write_clamped(o_write_clamped),
    .i_adc(i_adc), .i_volt_offset_disable(i_volt_offset_disable),
    .o_boost_voltage_mv(o_boost_voltage_mv), .o_boost_current_ma(o_boost_current_ma));
  brl_adc_model u_adc (.i_clock(i_clock), .i_go(adc_go), .i_codes(16'ha53c), .o_adc(i_adc));
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Extra idle edge keeps one assignment per time step and lets mV outputs settle
  task automatic wr(input logic [7:0] cmd, input logic [15:0] data, input logic [1:0] flags);
    i_req = {1'b1, 1'b0, cmd, data};
    @(negedge i_clock);
    i_req = '0;
    check({14'h0, o_write_rejected, o_write_clamped}, {14'h0, flags}, "write flags");
    @(negedge i_clock);
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
    i_req = {1'b0, 1'b1, cmd, 16'h0000};
    @(negedge i_clock);
    i_req = '0;
    check({15'h0, o_rvalid}, 16'h0001, "read valid");
    check(o_rdata, exp, "read data");
    @(negedge i_clock);
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d, checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(negedge i_clock);
    i_reset_n = 1;
    @(negedge i_clock);
    check(o_boost_voltage_mv, 16'd1280, "offset only");
    rd(BRL_BOOST_VOLT_OFF, 16'h0000);
    rd(BRL_BOOST_CURR_OFF, 16'h0000);
    wr(BRL_BOOST_VOLT_OFF, 16'h2003, 2'b00);
    rd(BRL_BOOST_VOLT_OFF, 16'h2000);
    check(o_boost_voltage_mv, 16'd17936, "volt with offset");
    i_volt_offset_disable = 1;
    @(negedge i_clock);
    check(o_boost_voltage_mv, 16'd16656, "volt no offset");
    wr(BRL_BOOST_VOLT_OFF, 16'h4400, 2'b10);
    wr(BRL_BOOST_VOLT_OFF, 16'h3ffc, 2'b01);
    wr(BRL_BOOST_VOLT_OFF, 16'h0004, 2'b01);
    rd(BRL_BOOST_VOLT_OFF, 16'h2000);
    wr(BRL_BOOST_CURR_OFF, 16'h7fff, 2'b00);
    wr(BRL_BOOST_CURR_OFF, 16'h8100, 2'b10);
    rd(BRL_BOOST_CURR_OFF, 16'h7f00);
    check({3'h0, o_boost_current_ma}, 16'd6350, "current ma");
    adc_go <= 1'b1;
    @(negedge i_clock);
    adc_go <= 1'b0;
    @(negedge i_clock);
    rd(BRL_ADC_READBACK_OFF, 16'ha53c);
    wr(BRL_ADC_READBACK_OFF, 16'h1234, 2'b00);
    rd(BRL_ADC_READBACK_OFF, 16'ha53c);
    rd(8'h40, 16'h0000);
    tally_and_finish;
  end
endmodule // testbench
